// file: timer_map.svh
// register offsets, field positions, reset values and timing counts of the 8-bit timer
// assumes inclusion by bare name from the design modules and the bench
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

`define TMR_OFF_COUNT 12'h000
`define TMR_OFF_CONFIG 12'h004
`define TMR_OFF_IRQ_CONTROL 12'h008
`define TMR_OFF_STATUS 12'h00C
`define TMR_OFF_MASK 12'h010
`define TMR_OFF_CONTROL 12'h014

`define TMR_CFG_RATE_LSB 0
`define TMR_CFG_ASSIGN_BIT 3
`define TMR_CFG_EDGE_BIT 4
`define TMR_CFG_SOURCE_BIT 5
`define TMR_IRQC_FLAG_BIT 0
`define TMR_IRQC_ENABLE_BIT 1
`define TMR_CTRL_SLEEP_BIT 0
`define TMR_CTRL_WDCLR_BIT 1
`define TMR_STAT_OVF_BIT 0
`define TMR_STAT_WRITE_BIT 1

`define TMR_CONFIG_RESET 8'hFF
`define TMR_COUNT_RESET 8'h00

`define TMR_INSTR_CYCLE_CLKS 4
`define TMR_WRITE_HOLD_CYCLES 2

`endif

// file: timer_pkg.sv
// types shared by the 8-bit timer modules
// assumes timer_map.svh alongside
package timer_pkg;

typedef struct packed {
    logic source_select;
    logic edge_select;
    logic prescaler_assign;
    logic [2:0] prescale_rate;
} timer_config_t;

typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
} apb_req_t;

typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
} apb_rsp_t;

typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
} phase_t;

endpackage : timer_pkg

// file: timer_prescaler.sv
// shared prescaler: 8-bit synchronous counter with tap selection
// assumes one clock; advance and clear are one-cycle pulses
`timescale 1ns/1ps
`include "timer_map.svh"

module timer_prescaler #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clear,
    input wire logic advance,
    input wire logic [2:0] rate,
    output logic tick
);

typedef struct packed {
    logic [WIDTH-1:0] count;
    logic tick;
} pre_state_t;

pre_state_t st_reg;
pre_state_t st_next;

logic [WIDTH-1:0] bumped;
assign bumped = st_reg.count + WIDTH'(1);

always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (clear) begin
        st_next.count = '0;
    end else if (advance) begin
        st_next.count = bumped;
        // rate k divides by two to the power k plus one
        st_next.tick = st_reg.count[rate] & ~bumped[rate];
    end
end

always_ff @(posedge clk_sys) begin
    if (reset) begin
        st_reg <= '0;
    end else begin
        st_reg <= st_next;
    end
end

assign tick = st_reg.tick;

endmodule : timer_prescaler

// file: timer_sync.sv
// input edge catcher for the external count source
// assumes the input is synchronous to clk_sys
`timescale 1ns/1ps

module timer_sync (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic pin,
    input wire logic falling,
    output logic edge_pulse
);

logic prev_reg;

always_ff @(posedge clk_sys) begin
    if (reset) begin
        prev_reg <= 1'b0;
    end else begin
        prev_reg <= pin;
    end
end

// chosen edge of the count input
assign edge_pulse = falling ? (prev_reg & ~pin) : (~prev_reg & pin);

endmodule : timer_sync

// file: eight_bit_timer.sv
// 8-bit timer/counter with shared prescaler, overflow flag and APB register access
// assumes an APB master on clk_sys and an ext_count_input synchronous to clk_sys
//
// Behaviour
// - one 8-bit count register, timer or event counter by software choice
// - source select clear: timer mode, one count per instruction cycle unprescaled
// - after a count write, counting is held off two instruction cycles
// - counter mode counts external input edges, rising or falling by edge select
// - source select set to one selects counter mode on the external input
// - one prescaler, timer or watchdog; assign bit clear gives it to timer
// - prescaler to timer gives eight ratios 1:2 to 1:256 by rate field
// - timer counts 1:1 only when assign bit hands prescaler to watchdog
// - prescaler not accessible; count write clears it while assigned to timer
// - rollover from FF to 00 sets overflow flag regardless of enable
// - hardware never clears the overflow flag; firmware clears it by writing
// - interrupt requested only while overflow flag and enable both set
// - timer frozen in sleep, so its overflow never wakes the processor
// - counter mode samples prescaler output on Q2 and Q4 before counting; here sampled on Q2 only, then counted on Q4
// - count contents unchanged for the whole of sleep
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "timer_map.svh"

module eight_bit_timer #(
    parameter int CYCLE_CLKS = `TMR_INSTR_CYCLE_CLKS,
    parameter int HOLD_CYCLES = `TMR_WRITE_HOLD_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_count_input,
    input wire logic sleep_mode,
    output logic irq,
    output logic overflow_irq_request,
    output logic watchdog_clear_instr,
    output logic watchdog_prescale_tick
);

////////////////////////////////////////////////////////////////////////////////
// state

typedef struct packed {
    logic [7:0] timer_count;
    timer_pkg::timer_config_t cfg;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic [1:0] status;
    logic [1:0] mask;
    logic sleep_sw;
    logic [1:0] hold_cnt;
    logic [1:0] div_cnt;
    timer_pkg::phase_t phase;
    logic ext_seen;
    logic sample_q2;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic req;
    logic wd_clear;
    logic wd_tick;
} timer_state_t;

timer_state_t st_reg;
timer_state_t st_next;

////////////////////////////////////////////////////////////////////////////////
// helpers

function automatic logic is_addr(input logic [31:0] a, input logic [11:0] off);
    is_addr = (a[11:0] == off) && (a[31:12] == 20'h00000);
endfunction : is_addr

function automatic logic [31:0] pad8(input logic [7:0] v);
    pad8 = {24'h000000, v};
endfunction : pad8

logic access;
logic wr;
logic rd;
logic instr_tick;
logic ext_edge;
logic pre_clear;
logic pre_advance;
logic pre_tick;
logic sleeping;
logic count_write;
logic [7:0] cfg_bits;

assign access = psel & penable & ~st_reg.pready;
assign wr = access & pwrite;
assign rd = access & ~pwrite;
assign sleeping = sleep_mode | st_reg.sleep_sw;
assign instr_tick = (st_reg.div_cnt == 2'(CYCLE_CLKS - 1));
assign count_write = wr & is_addr(paddr, `TMR_OFF_COUNT);
assign cfg_bits = {2'b00, st_reg.cfg};

////////////////////////////////////////////////////////////////////////////////
// submodules

timer_sync u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin(ext_count_input),
    .falling(st_reg.cfg.edge_select),
    .edge_pulse(ext_edge)
);

// prescaler cleared by a count write while on the timer, or by watchdog clear while on the watchdog
assign pre_clear = (count_write & ~st_reg.cfg.prescaler_assign)
    | (st_reg.wd_clear & st_reg.cfg.prescaler_assign);
assign pre_advance = ~sleeping & (st_reg.cfg.prescaler_assign ? instr_tick
    : (st_reg.cfg.source_select ? ext_edge : instr_tick));

timer_prescaler #(
    .WIDTH(8)
) u_pre (
    .clk_sys(clk_sys),
    .reset(reset),
    .clear(pre_clear),
    .advance(pre_advance),
    .rate(st_reg.cfg.prescale_rate),
    .tick(pre_tick)
);

////////////////////////////////////////////////////////////////////////////////
// next state

logic inc_src;
logic inc;
logic [7:0] count_plus;

always_comb begin
    st_next = st_reg;
    st_next.wd_clear = 1'b0;
    st_next.wd_tick = st_reg.cfg.prescaler_assign & pre_tick;
    inc_src = 1'b0;
    inc = 1'b0;
    count_plus = st_reg.timer_count + 8'h01;

    // instruction cycle divider and phase clocks
    if (!sleeping) begin
        st_next.div_cnt = instr_tick ? 2'h0 : st_reg.div_cnt + 2'h1;
        st_next.phase = timer_pkg::phase_t'(st_next.div_cnt);
    end

    // source selection
    if (!st_reg.cfg.prescaler_assign) begin
        inc_src = pre_tick;
    end else if (st_reg.cfg.source_select) begin
        inc_src = ext_edge;
    end else begin
        inc_src = instr_tick;
    end

    // counter mode: latch source event, sample on Q2 then count on Q4
    if (st_reg.cfg.source_select) begin
        if (inc_src) begin
            st_next.ext_seen = 1'b1;
        end
        if (st_reg.phase == timer_pkg::PH_Q2 && instr_tick == 1'b0) begin
            st_next.sample_q2 = st_reg.ext_seen | inc_src;
        end
        inc = (st_reg.phase == timer_pkg::PH_Q4) && st_reg.sample_q2;
        if (inc) begin
            st_next.ext_seen = inc_src;
            st_next.sample_q2 = 1'b0;
        end
    end else begin
        inc = inc_src;
        st_next.ext_seen = 1'b0;
        st_next.sample_q2 = 1'b0;
    end

    // write hold-off counted in instruction cycles
    if (st_reg.hold_cnt != 2'h0 && instr_tick && !sleeping) begin
        st_next.hold_cnt = st_reg.hold_cnt - 2'h1;
    end
    if (sleeping || st_reg.hold_cnt != 2'h0) begin
        inc = 1'b0;
    end

    // count advance and rollover
    if (inc) begin
        st_next.timer_count = count_plus;
        if (st_reg.timer_count == 8'hFF) begin
            st_next.overflow_flag = 1'b1;
            st_next.status[`TMR_STAT_OVF_BIT] = 1'b1;
        end
    end

    // APB slave: single-wait answer
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;
    if (access) begin
        st_next.pready = 1'b1;
        st_next.prdata = 32'h00000000;
        if (is_addr(paddr, `TMR_OFF_COUNT)) begin
            st_next.prdata = pad8(st_reg.timer_count);
            if (wr) begin
                st_next.timer_count = pwdata[7:0];
                st_next.hold_cnt = 2'(HOLD_CYCLES);
                st_next.status[`TMR_STAT_WRITE_BIT] = 1'b1;
            end
        end else if (is_addr(paddr, `TMR_OFF_CONFIG)) begin
            st_next.prdata = pad8(cfg_bits);
            if (wr) begin
                st_next.cfg = pwdata[5:0];
            end
        end else if (is_addr(paddr, `TMR_OFF_IRQ_CONTROL)) begin
            st_next.prdata = pad8({6'h00, st_reg.overflow_irq_enable, st_reg.overflow_flag});
            if (wr) begin
                st_next.overflow_irq_enable = pwdata[`TMR_IRQC_ENABLE_BIT];
                // set by a rollover in this cycle wins over the write
                st_next.overflow_flag = st_next.overflow_flag & pwdata[`TMR_IRQC_FLAG_BIT]
                    | (inc && st_reg.timer_count == 8'hFF)
                    | (pwdata[`TMR_IRQC_FLAG_BIT] & st_reg.overflow_flag);
            end
        end else if (is_addr(paddr, `TMR_OFF_STATUS)) begin
            st_next.prdata = pad8({6'h00, st_reg.status});
            if (rd) begin
                // clear on read, new events survive
                st_next.status = st_reg.status & 2'b00
                    | {count_write, inc && st_reg.timer_count == 8'hFF};
            end
        end else if (is_addr(paddr, `TMR_OFF_MASK)) begin
            st_next.prdata = pad8({6'h00, st_reg.mask});
            if (wr) begin
                st_next.mask = pwdata[1:0];
            end
        end else if (is_addr(paddr, `TMR_OFF_CONTROL)) begin
            st_next.prdata = pad8({6'h00, 1'b0, st_reg.sleep_sw});
            if (wr) begin
                st_next.sleep_sw = pwdata[`TMR_CTRL_SLEEP_BIT];
                st_next.wd_clear = pwdata[`TMR_CTRL_WDCLR_BIT];
            end
        end else begin
            st_next.pslverr = 1'b1;
        end
    end

    // outputs
    st_next.req = st_next.overflow_flag & st_next.overflow_irq_enable;
    st_next.irq = |(st_next.status & st_next.mask);
end

always_ff @(posedge clk_sys) begin
    if (reset) begin
        st_reg <= '0;
        st_reg.cfg <= timer_pkg::timer_config_t'(6'(`TMR_CONFIG_RESET));
        st_reg.timer_count <= `TMR_COUNT_RESET;
    end else begin
        st_reg <= st_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// outputs

assign prdata = st_reg.prdata;
assign pready = st_reg.pready;
assign pslverr = st_reg.pslverr;
assign irq = st_reg.irq;
assign overflow_irq_request = st_reg.req;
assign watchdog_clear_instr = st_reg.wd_clear;
assign watchdog_prescale_tick = st_reg.wd_tick;

endmodule : eight_bit_timer

// file: count_source.sv
// external count pulse source for the timer
// assumes clk_sys from the bench
`timescale 1ns/1ps
module count_source (
    input wire logic clk_sys,
    output logic pulse_out
);
    initial pulse_out = 1'b0;
    // slow pulses, line idles low
    task automatic burst(input int n);
        repeat (n) begin
            repeat (8) @(posedge clk_sys);
            pulse_out <= 1'b1;
            repeat (8) @(posedge clk_sys);
            pulse_out <= 1'b0;
        end
    endtask : burst
endmodule : count_source

// file: eight_bit_timer_properties.sv
// checker for the 8-bit timer ports
// assumes bind onto eight_bit_timer, one clock
`timescale 1ns/1ps
module eight_bit_timer_properties (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sleep_mode,
    input wire logic overflow_irq_request,
    input wire logic watchdog_clear_instr
);
    logic [3:0] age_reg;
    logic [3:0] age_next;
    always_comb age_next = (psel && penable) ? 4'h0 : age_reg + 4'(age_reg != 4'hF);
    always_ff @(posedge clk_sys) age_reg <= reset ? 4'h0 : age_next;
    ////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    chk_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    chk_data_width: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_idle_ready: assert property (!psel |=> !pready)
        else $error("pready while idle");
    chk_clear_pulse: assert property (watchdog_clear_instr |=> !watchdog_clear_instr)
        else $error("watchdog clear too long");
    chk_clear_cause: assert property (watchdog_clear_instr |-> age_reg <= 4'h3)
        else $error("watchdog clear without write");
    chk_flag_sticky: assert property ($fell(overflow_irq_request) |-> age_reg <= 4'h4)
        else $error("flag cleared by hardware");
    chk_sleep_frozen: assert property (sleep_mode && $past(sleep_mode) && $past(sleep_mode, 3)
        && age_reg > 4'h4 |-> !$rose(overflow_irq_request)) else $error("overflow in sleep");
    cov_err: cover property (pslverr);
    cov_ovf: cover property ($rose(overflow_irq_request));
    cov_clr: cover property (watchdog_clear_instr);
endmodule : eight_bit_timer_properties
bind eight_bit_timer eight_bit_timer_properties i_props (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
    .overflow_irq_request(overflow_irq_request), .watchdog_clear_instr(watchdog_clear_instr));

// file: eight_bit_timer_tb_top.sv
// bench for the 8-bit timer: apb master, scenarios, verdict
// assumes timer_map.svh, timer_pkg, count_source
`timescale 1ns/1ps
`include "timer_map.svh"
module eight_bit_timer_tb_top;
    localparam logic [11:0] CNT = `TMR_OFF_COUNT, CFG = `TMR_OFF_CONFIG, IRQC = `TMR_OFF_IRQ_CONTROL;
    localparam logic [11:0] STAT = `TMR_OFF_STATUS, MSK = `TMR_OFF_MASK, CTL = `TMR_OFF_CONTROL;
    logic clk_sys = 1'b0, reset = 1'b1, sleep_mode = 1'b0;
    timer_pkg::apb_req_t req = '0;
    timer_pkg::apb_rsp_t rsp;
    logic ext_in, irq, ovf, wd_clr, wd_tick, err;
    logic [31:0] rd;
    int failures = 0, samples_checked = 0, wd_clears = 0, wd_ticks = 0;
    eight_bit_timer i_dut (.clk_sys(clk_sys), .reset(reset), .paddr(req.paddr), .psel(req.psel),
        .penable(req.penable), .pwrite(req.pwrite), .pwdata(req.pwdata), .prdata(rsp.prdata),
        .pready(rsp.pready), .pslverr(rsp.pslverr), .ext_count_input(ext_in), .sleep_mode(sleep_mode),
        .irq(irq), .overflow_irq_request(ovf), .watchdog_clear_instr(wd_clr), .watchdog_prescale_tick(wd_tick));
    count_source i_src (.clk_sys(clk_sys), .pulse_out(ext_in));
    initial forever #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        wd_clears <= wd_clears + int'(wd_clr);
        wd_ticks <= wd_ticks + int'(wd_tick);
    end
    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        @(posedge clk_sys);
        req <= '{{20'h0, a}, 1'b1, 1'b0, w, {24'h0, d}};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    function automatic logic [7:0] cfg(logic s, logic e, logic a, logic [2:0] r);
        timer_pkg::timer_config_t c;
        c = '{s, e, a, r};
        return {2'b00, c};
    endfunction : cfg
    task automatic step(input logic [7:0] c, input int gap, input logic [7:0] exp);
        logic [7:0] a;
        apb(CFG, 1'b1, c);
        apb(CNT, 1'b0, 8'h00);
        a = rd[7:0];
        repeat (gap - 4) @(posedge clk_sys);
        apb(CNT, 1'b0, 8'h00);
        check(8'(rd[7:0] - a), exp, "count step");
    endtask : step
    ////////////////////////////////////////
    task automatic t_reset;
        apb(CNT, 1'b0, 8'h00);
        check(rd, 32'h0, "count");
        apb(CFG, 1'b0, 8'h00);
        check(rd, 32'h3F, "config");
        apb(12'h018, 1'b0, 8'h00);
        check(err, 1'b1, "unmapped");
    endtask : t_reset
    task automatic t_rates;
        int t0;
        step(cfg(0, 0, 0, 0), 40, 5);
        t0 = wd_ticks;
        for (int r = 1; r < 8; r++) step(cfg(0, 0, 0, r[2:0]), 20 << (r + 1), 5);
        check(wd_ticks - t0, 0, "watchdog ticks");
        step(cfg(0, 0, 1, 7), 40, 10);
    endtask : t_rates
    task automatic t_hold;
        apb(CNT, 1'b1, 8'hF0);
        repeat (36) @(posedge clk_sys);
        apb(CNT, 1'b0, 8'h00);
        check(rd[7:0] inside {8'hF7, 8'hF8}, 1'b1, "held count");
        // 1:256 on the timer; a count write restarts the prescaler, so no tick for 1024 clocks
        apb(CFG, 1'b1, cfg(0, 0, 0, 7));
        apb(CNT, 1'b1, 8'h00);
        repeat (900) @(posedge clk_sys);
        apb(CNT, 1'b0, 8'h00);
        check(rd, 32'h0, "prescaler cleared");
        apb(CFG, 1'b1, cfg(0, 0, 1, 7));
    endtask : t_hold
    task automatic t_overflow;
        apb(IRQC, 1'b1, 8'h02);
        apb(MSK, 1'b1, 8'h01);
        apb(CNT, 1'b1, 8'hFE);
        repeat (40) @(posedge clk_sys);
        check(ovf, 1'b1, "request");
        check(irq, 1'b1, "irq");
        apb(STAT, 1'b0, 8'h00);
        check(rd[0], 1'b1, "status");
        repeat (3) @(posedge clk_sys);
        check({irq, ovf}, 2'b01, "after status read");
        apb(IRQC, 1'b1, 8'h00);
        apb(CNT, 1'b1, 8'hFE);
        repeat (40) @(posedge clk_sys);
        apb(IRQC, 1'b0, 8'h00);
        check({rd[1:0], ovf}, 3'b010, "flag without enable");
        apb(IRQC, 1'b1, 8'h00);
    endtask : t_overflow
    task automatic t_counter;
        logic [7:0] a;
        for (int k = 0; k < 3; k++) begin
            apb(CFG, 1'b1, cfg(1, k[0], k < 2, 0));
            apb(CNT, 1'b0, 8'h00);
            a = rd[7:0];
            i_src.burst(8);
            repeat (16) @(posedge clk_sys);
            apb(CNT, 1'b0, 8'h00);
            check(8'(rd[7:0] - a), k < 2 ? 8 : 4, "events");
        end
    endtask : t_counter
    task automatic t_sleep;
        logic [7:0] a;
        apb(CFG, 1'b1, cfg(0, 0, 1, 0));
        sleep_mode <= 1'b1;
        apb(CNT, 1'b0, 8'h00);
        a = rd[7:0];
        repeat (40) @(posedge clk_sys);
        apb(CNT, 1'b0, 8'h00);
        check(rd[7:0], a, "sleep count");
        sleep_mode <= 1'b0;
    endtask : t_sleep
    task automatic t_move;
        int c0 = wd_clears;
        apb(CTL, 1'b1, 8'h02);
        apb(CNT, 1'b1, 8'h00);
        apb(CFG, 1'b1, cfg(0, 0, 1, 3));
        apb(CTL, 1'b1, 8'h02);
        apb(CFG, 1'b1, cfg(0, 0, 1, 5));
        apb(CTL, 1'b1, 8'h02);
        apb(CFG, 1'b1, cfg(0, 0, 0, 3));
        repeat (2) @(posedge clk_sys);
        check(wd_clears - c0, 3, "watchdog clears");
    endtask : t_move
    ////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    initial begin
        #400000;
        failures++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        t_reset();
        t_rates();
        t_hold();
        t_overflow();
        t_counter();
        t_sleep();
        t_move();
        final_report();
    end
endmodule : eight_bit_timer_tb_top
